// ===== rtl/timer_clock_pkg.sv
package timer_clock_pkg;

   // special function space decode
   localparam logic [7:0] TIMER_CLOCK_CONTROL_ADDR  = 8'h8e;
   localparam logic [7:0] TIMER_CLOCK_CONTROL_RESET = 8'h01;

   // field positions inside the clock control byte
   localparam int         TIMER0_SEL_BIT     = 3;
   localparam int         TIMER1_SEL_BIT     = 4;
   localparam int         TIMER2_SEL_BIT     = 5;
   localparam int         STRETCH_LSB        = 0;
   localparam int         STRETCH_WIDTH      = 3;

   // prescale ratios of the cpu clock
   localparam int         DIV_SLOW           = 12;
   localparam int         DIV_FAST           = 4;
   localparam int         DIV_CNT_WIDTH      = 4;
   localparam logic [3:0] DIV_CNT_LAST       = 4'(DIV_SLOW - 1);
   localparam logic [1:0] DIV_FAST_LAST      = 2'(DIV_FAST - 1);
   localparam logic [3:0] DIV_CNT_RESET      = 4'h0;

endpackage

// ===== rtl/timer_clock_prescale_select.sv
// Notes on behaviour
// R1 - bit 3 set: timer 0 ticks at cpu clock / 4, clear: / 12
// R2 - bit 4 set: timer 1 ticks at cpu clock / 4, clear: / 12
// R3 - bit 5 set: timer 2 ticks at cpu clock / 4, clear: / 12
// R4 - clock control register decoded at address 0x8E, read and write by direct access
// R5 - register resets to 0000 0001, so all timers start at divide by 12
// R6 - register also holds external data move stretch cycle control
// R7 - software keeps bits 7, 6 and 2 to 0 unchanged when it writes; the register takes all eight bits of any write, and the testbench writes 8'hc7
`timescale 1ns/10ps
`default_nettype none

module timer_clock_prescale_select (
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr_en,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_rd_en,
   output logic      [7:0] reg_rdata,
   output logic            reg_rd_valid,
   output logic      [7:0] timer_clock_control,
   output logic            timer0_tick,
   output logic            timer1_tick,
   output logic            timer2_tick,
   output logic      [2:0] external_data_move_stretch
);
   import timer_clock_pkg::*;

   typedef struct packed {
      logic [7:0]               ctl;
      logic [DIV_CNT_WIDTH-1:0] cnt;
      logic                     tick0;
      logic                     tick1;
      logic                     tick2;
      logic [7:0]               rdata;
      logic                     rd_valid;
   } state_s;

   state_s state_r;
   state_s state_nxt;
   logic   wr_hit;
   logic   rd_hit;
   logic   slow_due;
   logic   fast_due;

   // a timer tick is due on the slow wrap, or every fourth phase when fast
   function automatic logic tick_due(input logic fast_sel, input logic slow, input logic fast);
      tick_due = fast_sel ? fast : slow;
   endfunction

   // register decode in the special function space
   assign wr_hit   = reg_wr_en && (reg_addr == TIMER_CLOCK_CONTROL_ADDR); // R4
   assign rd_hit   = reg_rd_en && (reg_addr == TIMER_CLOCK_CONTROL_ADDR); // R4
   assign slow_due = (state_r.cnt == DIV_CNT_LAST);
   assign fast_due = (state_r.cnt[1:0] == DIV_FAST_LAST);

   // next state: register write, read answer and shared prescaler
   always_comb begin
      state_nxt          = state_r;
      state_nxt.rd_valid = 1'b0;
      if (wr_hit) begin
         state_nxt.ctl = reg_wdata; // R4 R6
      end
      if (rd_hit) begin
         state_nxt.rdata    = state_r.ctl; // R4
         state_nxt.rd_valid = 1'b1;
      end
      if (slow_due) begin
         state_nxt.cnt = DIV_CNT_RESET;
      end else begin
         state_nxt.cnt = state_r.cnt + 4'h1;
      end
      state_nxt.tick0 = tick_due(state_r.ctl[TIMER0_SEL_BIT], slow_due, fast_due); // R1
      state_nxt.tick1 = tick_due(state_r.ctl[TIMER1_SEL_BIT], slow_due, fast_due); // R2
      state_nxt.tick2 = tick_due(state_r.ctl[TIMER2_SEL_BIT], slow_due, fast_due); // R3
   end

   // state register
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_r          <= '0;
         state_r.ctl      <= TIMER_CLOCK_CONTROL_RESET; // R5
         state_r.cnt      <= DIV_CNT_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // outputs straight from the state flops
   assign reg_rdata                  = state_r.rdata;
   assign reg_rd_valid               = state_r.rd_valid;
   assign timer_clock_control        = state_r.ctl;
   assign timer0_tick                = state_r.tick0;
   assign timer1_tick                = state_r.tick1;
   assign timer2_tick                = state_r.tick2;
   assign external_data_move_stretch = state_r.ctl[STRETCH_LSB +: STRETCH_WIDTH]; // R6

   // checks on the register and tick behaviour
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   // register and outputs come out of reset at their idle values
   AST_RESET_VALUE: assert property ( // R5
      $rose(rstn) |-> (timer_clock_control == TIMER_CLOCK_CONTROL_RESET))
      else $error("clock control reset value wrong");

   AST_RESET_QUIET: assert property ( // R5
      $rose(rstn) |-> (!timer0_tick && !timer1_tick && !timer2_tick &&
                       !reg_rd_valid && (reg_rdata == 8'h00)))
      else $error("outputs not idle after reset");

   // a write hit lands in the register one cycle later
   AST_WRITE_TAKES: assert property ( // R4
      wr_hit |=> (timer_clock_control == $past(reg_wdata)))
      else $error("clock control write not taken");

   // without a write hit the register keeps its value
   AST_HOLD_NO_WRITE: assert property ( // R4
      !wr_hit |=> $stable(timer_clock_control))
      else $error("clock control changed without a write");

   // a read hit answers one cycle later with the register value
   AST_READ_BACK: assert property ( // R4
      rd_hit |=> (reg_rd_valid && (reg_rdata == $past(timer_clock_control))))
      else $error("clock control read answer wrong");

   // other addresses and idle cycles give no answer
   AST_READ_QUIET: assert property ( // R4
      !rd_hit |=> !reg_rd_valid)
      else $error("read answer without a read hit");

   // read data holds until the next read hit
   AST_RDATA_HOLD: assert property ( // R4
      !rd_hit |=> $stable(reg_rdata))
      else $error("read data changed without a read hit");

   // the shared prescaler never leaves its twelve phases
   AST_CNT_RANGE: assert property ( // R1 R2 R3
      state_r.cnt <= DIV_CNT_LAST)
      else $error("prescaler phase out of range");

   // timer 0 ticks only at a due phase of its selected rate
   AST_T0_RATE: assert property ( // R1
      timer0_tick |-> ($past(state_r.cnt) == DIV_CNT_LAST ||
                       ($past(timer_clock_control[TIMER0_SEL_BIT]) &&
                        $past(state_r.cnt[1:0]) == DIV_FAST_LAST)))
      else $error("timer 0 tick at wrong phase");

   // timer 0 fast tick on every fourth phase
   AST_T0_FAST: assert property ( // R1
      (timer_clock_control[TIMER0_SEL_BIT] && fast_due) |=> timer0_tick)
      else $error("timer 0 fast tick missing");

   // timer 0 slow tick: no tick for eight cycles unless switched fast
   AST_T0_SLOW_GAP: assert property ( // R1
      (!timer_clock_control[TIMER0_SEL_BIT] && timer0_tick)
         |=> ($past(timer_clock_control[TIMER0_SEL_BIT]) || !timer0_tick) [*8])
      else $error("timer 0 slow tick too soon");

   // timer 0 tick is a single-cycle pulse
   AST_T0_PULSE: assert property ( // R1
      timer0_tick |=> !timer0_tick)
      else $error("timer 0 tick longer than one cycle");

   // timer 1 tick on every due phase of its selected rate
   AST_T1_RATE: assert property ( // R2
      (timer_clock_control[TIMER1_SEL_BIT] ? fast_due : slow_due) |=> timer1_tick)
      else $error("timer 1 tick missing");

   // timer 1 ticks only at a due phase
   AST_T1_ONLY_DUE: assert property ( // R2
      timer1_tick |-> ($past(slow_due) ||
                       ($past(timer_clock_control[TIMER1_SEL_BIT]) && $past(fast_due))))
      else $error("timer 1 tick at wrong phase");

   // timer 1 slow tick: no tick for eight cycles unless switched fast
   AST_T1_SLOW_GAP: assert property ( // R2
      (!timer_clock_control[TIMER1_SEL_BIT] && timer1_tick)
         |=> ($past(timer_clock_control[TIMER1_SEL_BIT]) || !timer1_tick) [*8])
      else $error("timer 1 slow tick too soon");

   // timer 1 tick is a single-cycle pulse
   AST_T1_PULSE: assert property ( // R2
      timer1_tick |=> !timer1_tick)
      else $error("timer 1 tick longer than one cycle");

   // timer 2 tick on every due phase of its selected rate
   AST_T2_FAST: assert property ( // R3
      (timer_clock_control[TIMER2_SEL_BIT] ? fast_due : slow_due) |=> timer2_tick)
      else $error("timer 2 tick missing");

   // timer 2 ticks only at a due phase
   AST_T2_ONLY_DUE: assert property ( // R3
      timer2_tick |-> ($past(slow_due) ||
                       ($past(timer_clock_control[TIMER2_SEL_BIT]) && $past(fast_due))))
      else $error("timer 2 tick at wrong phase");

   // timer 2 slow tick: no tick for eight cycles unless switched fast
   AST_T2_SLOW: assert property ( // R3
      (!timer_clock_control[TIMER2_SEL_BIT] && timer2_tick)
         |=> ($past(timer_clock_control[TIMER2_SEL_BIT]) || !timer2_tick) [*8])
      else $error("timer 2 slow tick too soon");

   // timer 2 tick is a single-cycle pulse
   AST_T2_PULSE: assert property ( // R3
      timer2_tick |=> !timer2_tick)
      else $error("timer 2 tick longer than one cycle");

   // stretch control taken from the low bits of a write
   AST_STRETCH: assert property ( // R6
      wr_hit |=> (external_data_move_stretch == $past(reg_wdata[2:0])))
      else $error("stretch field not taken from write");

   // stretch output always mirrors its register field
   AST_STRETCH_FOLLOWS: assert property ( // R6
      external_data_move_stretch == timer_clock_control[STRETCH_LSB +: STRETCH_WIDTH])
      else $error("stretch output differs from register");

   // main scenarios: fast select write, reads, both tick rates
   COV_WRITE_FAST:  cover property (wr_hit && reg_wdata[TIMER0_SEL_BIT]);
   COV_READ:        cover property (rd_hit);
   COV_OTHER_READ:  cover property (reg_rd_en && !rd_hit);
   COV_FAST_TICKS:  cover property (timer2_tick ##4 timer2_tick);
   COV_SLOW_TICKS:  cover property (timer1_tick && !timer_clock_control[TIMER1_SEL_BIT]);

endmodule // timer_clock_prescale_select

`default_nettype wire

// ===== tb/timer_clock_prescale_select_tb.sv
`timescale 1ns/10ps
`default_nettype none
module timer_clock_prescale_select_tb;
   import timer_clock_pkg::*;
   logic       clk_sys, rstn, reg_wr_en, reg_rd_en, reg_rd_valid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, ctl;
   logic [2:0] tick, stretch;
   int         n_mismatch, total_checks, i;
   timer_clock_prescale_select timer_clock_prescale_select_inst (.clk_sys(clk_sys), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
      .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .timer_clock_control(ctl),
      .timer0_tick(tick[0]), .timer1_tick(tick[1]), .timer2_tick(tick[2]),
      .external_data_move_stretch(stretch));
   // free-running cpu clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one write strobe, then let the update land
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr_en <= 1'b1;
      @(posedge clk_sys);
      reg_wr_en <= 1'b0;
      #1;
   endtask
   // one read strobe; answer is looked at in its single cycle
   task automatic rd(input logic [7:0] a, input logic v, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk_sys);
      reg_rd_en <= 1'b0;
      #1;
      chk("rd_valid", {7'h00, v}, {7'h00, reg_rd_valid});
      if (v) chk("rdata", e, reg_rdata);
   endtask
   // cycles between two ticks of one timer
   task automatic per(input int k, input logic [7:0] e);
      logic [7:0] n;
      n = 8'h00;
      while (tick[k] !== 1'b1 && n < 8'h28) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      n = 8'h00;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (tick[k] !== 1'b1 && n < 8'h28);
      chk("tick period", e, n);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // hang guard at 5000 cycles, well past the couple of hundred cycles the tests need
   initial begin
      #50_000;
      n_mismatch++;
      summarize();
   end
   // test sequence
   initial begin
      {rstn, reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      #1;
      chk("ctl reset", TIMER_CLOCK_CONTROL_RESET, ctl);
      chk("stretch reset", 8'h01, {5'h00, stretch});
      rd(TIMER_CLOCK_CONTROL_ADDR, 1'b1, 8'h01);
      for (i = 0; i < 3; i++) per(i, 8'(DIV_SLOW));
      $display("test reset done");
      for (i = 0; i < 3; i++) begin
         wr(TIMER_CLOCK_CONTROL_ADDR, 8'h01 | (8'h08 << i));
         per(i, 8'(DIV_FAST));
         per((i + 1) % 3, 8'(DIV_SLOW));
      end
      $display("test rate select done");
      wr(TIMER_CLOCK_CONTROL_ADDR, 8'hc7);
      rd(TIMER_CLOCK_CONTROL_ADDR, 1'b1, 8'hc7);
      chk("stretch", 8'h07, {5'h00, stretch});
      wr(8'h8f, 8'h38);
      chk("ctl unmapped", 8'hc7, ctl);
      rd(8'h8f, 1'b0, 8'h00);
      $display("test access done");
      summarize();
   end
endmodule // timer_clock_prescale_select_tb
`default_nettype wire
